// *** tws_map.vh ***
// constants for the two-wire memory slave front end
// assumes ref_clk at 100 MHz, bus lines already synchronous to it
`ifndef TWS_MAP_VH
`define TWS_MAP_VH
`define TWS_ADDR_W      15
`define TWS_MEM_DEPTH   32768
`define TWS_TYPE_MSB    7
`define TWS_TYPE_LSB    4
`define TWS_SEL_MSB     3
`define TWS_SEL_LSB     1
`define TWS_RW_BIT      0
`define TWS_DEV_TYPE    4'h5
`define TWS_FIFO_DEPTH  4
`define TWS_FIFO_AW     2
`endif

// *** tws_slave.v ***
// two-wire memory slave: condition detect, byte engine, array, read fifo
// assumes scl/sda inputs are synchronous to ref_clk and much slower than it
`timescale 1ns/100ps
`include "tws_map.vh"

module tws_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             ref_clk,  // clock
    input  wire             sys_rst,  // async reset
    input  wire             flush,    // drop contents
    input  wire             in_valid, // write request
    output wire             in_ready, // room available
    input  wire [WIDTH-1:0] in_data,  // write data
    output wire             out_valid,// data available
    input  wire             out_ready,// drain request
    output wire [WIDTH-1:0] out_data  // head data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_q;
    reg [AW:0]      rd_q;
    wire            full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire            empty = (wr_q == rd_q);
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = mem[rd_q[AW-1:0]];
    // pointer update; full and empty from the extra wrap bit
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else if (flush) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && !full)
                wr_q <= wr_q + {{AW{1'b0}}, 1'b1};
            if (out_ready && !empty)
                rd_q <= rd_q + {{AW{1'b0}}, 1'b1};
        end
    end
    // storage has no reset, contents are don't-care until written
    always @(posedge ref_clk) begin
        if (in_valid && !full)
            mem[wr_q[AW-1:0]] <= in_data;
    end
endmodule // tws_fifo

module tws_slave #(
    parameter AW = `TWS_ADDR_W,
    parameter DEPTH = `TWS_MEM_DEPTH
) (
    input  wire       ref_clk,     // 100 MHz clock
    input  wire       sys_rst,     // async reset, active high
    input  wire       scl_i,       // serial clock in, never driven (slave only)
    input  wire       sda_i,       // serial data in
    output reg        sda_o,       // serial data out, always 0
    output reg        sda_oe,      // pull data low when high
    input  wire [2:0] device_select_straps, // strap pins
    input  wire       wp_i,        // write protect
    output reg        busy_o       // transaction in progress
);
    // one-hot states
    localparam S_IDLE = 6'h01;
    localparam S_DEV  = 6'h02;
    localparam S_AHI  = 6'h04;
    localparam S_ALO  = 6'h08;
    localparam S_WR   = 6'h10;
    localparam S_RD   = 6'h20;

    reg [7:0]    mem [0:DEPTH-1];
    reg [5:0]    st_q;
    reg          scl_q, sda_q;
    reg [7:0]    sh_q;
    reg [3:0]    bit_q;                    // 0..7 data, 8 ack
    reg [AW-1:0] addr_q;
    reg          ack_q;                    // driving ack low
    reg          rd_drv_q;                 // driving read data
    reg          rdack_q;                  // ack seen at last ack slot (ours after read select, then master's)
    reg [7:0]    tx_q;
    reg          pf_q;

    wire scl_rise = scl_i & ~scl_q;
    wire scl_fall = ~scl_i & scl_q;
    wire start_c  = scl_i & scl_q & sda_q & ~sda_i;
    wire stop_c   = scl_i & scl_q & ~sda_q & sda_i;
    wire [7:0] byte_in = {sh_q[6:0], sda_i};

    // unconnected straps / wp resolve to 0 at the pads (pull-downs)
    wire [2:0] strap = device_select_straps;
    wire       prot  = wp_i;

    // read prefetch fifo keeps the next byte ready ahead of the falling edge
    wire       f_in_ready, f_out_valid;
    wire [7:0] f_out_data;
    wire       f_pop;
    tws_fifo #(.WIDTH(8), .DEPTH(`TWS_FIFO_DEPTH), .AW(`TWS_FIFO_AW)) u_fifo (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .flush    (start_c | stop_c | (st_q != S_RD)),
        .in_valid (pf_q),
        .in_ready (f_in_ready),
        .in_data  (mem[addr_q]),
        .out_valid(f_out_valid),
        .out_ready(f_pop),
        .out_data (f_out_data)
    );
    // pop one byte at the start of each read byte the master has asked for;
    // the drive flag is already down after every ack slot, so it cannot say first byte
    assign f_pop = (st_q == S_RD) && scl_fall && (bit_q == 4'h0) && rdack_q;

    // prefetch single byte per read slot; blocked by fifo back-pressure
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            pf_q <= 1'b0;
        else
            pf_q <= (st_q == S_RD) && !f_out_valid && f_in_ready && !pf_q;
    end

    // main bus engine
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= S_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            sh_q <= 8'h00;
            bit_q <= 4'h0;
            addr_q <= {AW{1'b0}};
            ack_q <= 1'b0;
            rd_drv_q <= 1'b0;
            rdack_q <= 1'b0;
            tx_q <= 8'h00;
            sda_o <= 1'b0;
            sda_oe <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            sda_o <= 1'b0;
            busy_o <= (st_q != S_IDLE);
            sda_oe <= ack_q | (rd_drv_q & ~tx_q[7]);
            if (start_c) begin
                st_q <= S_DEV;
                bit_q <= 4'h0;
                ack_q <= 1'b0;
                rd_drv_q <= 1'b0;
            end else if (stop_c) begin
                st_q <= S_IDLE;
                ack_q <= 1'b0;
                rd_drv_q <= 1'b0;
            end else if (st_q != S_IDLE && scl_rise) begin
                // sample phase; data only taken here, in the first cycle scl is seen high
                if (bit_q < 4'h8) begin
                    sh_q <= byte_in;
                    bit_q <= bit_q + 4'h1;
                end else begin
                    bit_q <= 4'h0;
                    rdack_q <= ~sda_i;
                end
            end else if (st_q != S_IDLE && scl_fall) begin
                // drive phase
                if (bit_q == 4'h8 && st_q != S_RD) begin
                    ack_q <= 1'b0;
                    rd_drv_q <= 1'b0;
                    case (st_q)
                    S_DEV: begin
                        if (sh_q[`TWS_TYPE_MSB:`TWS_TYPE_LSB] == `TWS_DEV_TYPE &&
                            sh_q[`TWS_SEL_MSB:`TWS_SEL_LSB] == strap) begin
                            ack_q <= 1'b1;
                            st_q <= sh_q[`TWS_RW_BIT] ? S_RD : S_AHI;
                        end else
                            st_q <= S_IDLE;
                    end
                    S_AHI: begin
                        addr_q[AW-1:8] <= sh_q[AW-9:0];
                        ack_q <= 1'b1;
                        st_q <= S_ALO;
                    end
                    S_ALO: begin
                        addr_q[7:0] <= sh_q;
                        ack_q <= 1'b1;
                        st_q <= S_WR;
                    end
                    S_WR: begin
                        if (!prot) begin
                            mem[addr_q] <= sh_q;
                            addr_q <= addr_q + {{(AW-1){1'b0}}, 1'b1};
                            ack_q <= 1'b1;
                        end else
                            st_q <= S_IDLE;
                    end
                    default: st_q <= S_IDLE;
                    endcase
                end else if (st_q == S_RD) begin
                    ack_q <= 1'b0;
                    if (bit_q == 4'h0) begin
                        if (rdack_q) begin
                            // new byte; array word already in the fifo
                            tx_q <= f_out_data;
                            rd_drv_q <= 1'b1;
                            addr_q <= addr_q + {{(AW-1){1'b0}}, 1'b1};
                        end else begin
                            rd_drv_q <= 1'b0;
                            st_q <= S_IDLE;
                        end
                        rdack_q <= 1'b0;
                    end else if (bit_q == 4'h8) begin
                        rd_drv_q <= 1'b0;                   // release for master ack
                    end else
                        tx_q <= {tx_q[6:0], 1'b0};
                end else
                    ack_q <= 1'b0;
            end
        end
    end
endmodule // tws_slave

// *** tws_slave_props.sv ***
// checker for the two-wire slave, watching only its top ports
// assumes scl_i/sda_i are resolved bus levels synchronous to ref_clk
`timescale 1ns/100ps
module tws_slave_props (
    input logic       ref_clk,              // clock
    input logic       sys_rst,              // async reset
    input logic       scl_i,                // serial clock level
    input logic       sda_i,                // serial data level
    input logic       sda_o,                // data out
    input logic       sda_oe,               // data pull enable
    input logic [2:0] device_select_straps, // straps
    input logic       wp_i,                 // write protect
    input logic       busy_o                // not idle
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // conditions only count once scl has been high for two samples
    sequence stop_s; scl_i && $past(scl_i) && $rose(sda_i); endsequence
    sequence start_s; scl_i && $past(scl_i) && $fell(sda_i); endsequence
    chk_drive_low_only: assert property (sda_oe |-> !sda_o)
        else $error("data driven high");
    chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i && !$past(scl_i))
        else $error("drive changed near scl high");
    chk_oe_rise_lag: assert property ($rose(sda_oe) |-> !$past(scl_i))
        else $error("drive started too soon after scl fall");
    chk_stop_idle: assert property (stop_s |-> ##[1:4] !busy_o)
        else $error("stop did not end the operation");
    chk_start_busy: assert property (start_s |-> ##[1:4] busy_o)
        else $error("start not taken");
    chk_start_quiet: assert property (start_s |=> !sda_oe [*8])
        else $error("drive right after start");
    chk_idle_quiet: assert property (!busy_o && $past(!busy_o) |-> !sda_oe)
        else $error("idle slave drives data");
    chk_drive_bit_long: assert property ($fell(sda_oe) |-> $past(sda_oe, 8))
        else $error("drive shorter than a bit");
    cover property (stop_s);
    cover property (start_s ##[1:400] $rose(sda_oe));
    cover property ($rose(sda_oe) ##[1:60] scl_i);
endmodule // tws_slave_props

bind tws_slave tws_slave_props tws_slave_props_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .wp_i(wp_i),
    .device_select_straps(device_select_straps), .busy_o(busy_o));

// *** tws_master_model.sv ***
// behavioural two-wire bus master, the slave's far side
// assumes the data line is resolved with a pull-up and fed back on sda
`timescale 1ns/100ps
module tws_master_model (
    input  logic ref_clk, // clock
    input  logic sda,     // resolved data line
    output logic scl,     // serial clock, made only here
    output logic pull     // high pulls data low
);
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // data set mid low phase, held through the high phase
    task automatic bit_io(input logic b, output logic r);
        pull = ~b;
        w(10);
        scl = 1'b1;
        w(10);
        r = sda;
        w(10);
        scl = 1'b0;
        w(10);
    endtask
    // eight bits msb first, then the ninth bit (released for writes)
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(a, r);
        ack = ~r;
    endtask
    task automatic start;
        pull = 1'b0;
        w(10);
        scl = 1'b1;
        w(10);
        pull = 1'b1;
        w(10);
        scl = 1'b0;
        w(10);
    endtask
    // called after writes, a select refused for its type, a read ending in nack and a cut-off byte; the slave has released the line each time
    task automatic stop;
        pull = 1'b1;
        w(10);
        scl = 1'b1;
        w(10);
        pull = 1'b0;
        w(10);
    endtask
endmodule // tws_master_model

// *** tws_slave_tb.sv ***
// self-checking bench for the two-wire memory slave
// assumes the master model as far side and a pull-up on the data line
`timescale 1ns/100ps
`include "tws_map.vh"
module tws_slave_tb;
    logic ref_clk, sys_rst, scl, pull, sda_o, sda_oe, busy, wp, ack, r;
    logic [2:0] straps;
    logic [7:0] q;
    int errors, n_checks, cyc;
    wire sda = ~(pull | (sda_oe & ~sda_o));
    tws_slave tws_slave_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .device_select_straps(straps), .wp_i(wp), .busy_o(busy));
    tws_master_model tws_master_model_inst (.ref_clk(ref_clk), .sda(sda), .scl(scl), .pull(pull));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic report_and_stop;
        if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // a hung bus cannot stall the run
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 50000) begin
            errors++;
            report_and_stop;
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tx(input logic [7:0] d, input logic a);
        tws_master_model_inst.xfer(d, a, q, ack);
    endtask
    task automatic sel(input logic rw, input logic [2:0] s, input logic exp);
        tws_master_model_inst.start;
        tx({`TWS_DEV_TYPE, s, rw}, 1'b1);
        chk(ack, exp);
    endtask
    task automatic seta(input logic [14:0] a);
        sel(1'b0, 3'h5, 1'b1);
        tx({1'b0, a[14:8]}, 1'b1);
        tx(a[7:0], 1'b1);
        sel(1'b1, 3'h5, 1'b1);
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d, input logic exp);
        sel(1'b0, 3'h5, 1'b1);
        tx({1'b0, a[14:8]}, 1'b1);
        tx(a[7:0], 1'b1);
        tx(d, 1'b1);
        chk(ack, exp);
        tws_master_model_inst.stop;
    endtask
    task automatic rd(input logic last, input logic [7:0] e);
        tx(8'hFF, last);
        chk(q, e);
    endtask
    initial begin
        sys_rst = 1'b1;
        wp = 1'b0;
        straps = 3'h5;
        repeat (8) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        tws_master_model_inst.w(2);
        // back-to-back writes across the top address, read wraps to zero
        wr(15'h7FFF, 8'hA5, 1'b1);
        wr(15'h0000, 8'h3C, 1'b1);
        seta(15'h7FFF);
        rd(1'b0, 8'hA5);
        rd(1'b1, 8'h3C);
        tws_master_model_inst.stop;
        // wrong straps or wrong type must stay silent
        sel(1'b0, 3'h2, 1'b0);
        tws_master_model_inst.start;
        tx({`TWS_DEV_TYPE ^ 4'h1, 3'h5, 1'b0}, 1'b1);
        chk(ack, 1'b0);
        tws_master_model_inst.stop;
        // protected write is refused and leaves the byte alone
        wr(15'h0010, 8'h11, 1'b1);
        wp = 1'b1;
        wr(15'h0010, 8'h77, 1'b0);
        wp = 1'b0;
        seta(15'h0010);
        rd(1'b1, 8'h11);
        tws_master_model_inst.stop;
        // half a data byte, then stop or start: nothing written
        wr(15'h0020, 8'h5A, 1'b1);
        for (int m = 0; m < 2; m++) begin
            sel(1'b0, 3'h5, 1'b1);
            tx(8'h00, 1'b1);
            tx(8'h20, 1'b1);
            repeat (4) tws_master_model_inst.bit_io(1'b0, r);
            if (m == 0) tws_master_model_inst.stop;
            if (m == 0) chk(busy, 1'b0);
            seta(15'h0020);
            rd(1'b1, 8'h5A);
            tws_master_model_inst.stop;
        end
        report_and_stop;
    end
endmodule // tws_slave_tb
